// ==== common/sktl_pkg.sv ====
// Package for the skip-test and timer-load execution block
`default_nettype none
package sktl_pkg;
    // Instruction codes (10-bit words)
    localparam logic [9:0] OP_SKIP_EXT_PIN_B = 10'h03b;
    localparam logic [9:0] OP_SKIP_POWERDOWN = 10'h003;
    localparam logic [9:0] OP_SKIP_TIMER_A = 10'h280;
    localparam logic [9:0] OP_SKIP_TIMER_B = 10'h281;
    localparam logic [9:0] OP_SKIP_TIMER_C = 10'h282;
    localparam logic [9:0] OP_SKIP_TIMER_D = 10'h283;
    localparam logic [9:0] OP_SKIP_TIMER_E = 10'h284;
    localparam logic [9:0] OP_ARM_VDET = 10'h2f3;
    localparam logic [9:0] OP_SKIP_BIT_BASE = 10'h020;
    localparam logic [9:0] OP_SKIP_CARRY = 10'h02f;
    localparam logic [9:0] OP_LOAD_TIMER_A = 10'h230;
    localparam logic [9:0] OP_LOAD_TIMER_B = 10'h231;
    localparam logic [9:0] OP_LOAD_TIMER_C = 10'h232;
    localparam logic [9:0] OP_LOAD_TIMER_D = 10'h233;
    // Field positions
    localparam int EXT_PIN_B_POL_BIT = 2;
    localparam int TIMER_A_IE_BIT = 2;
    localparam int TIMER_B_IE_BIT = 3;
    localparam int TIMER_C_IE_BIT = 0;
    localparam int TIMER_E_IE_BIT = 1;
    localparam int TIMER_D_IE_BIT = 3;
    localparam int NUM_TIMER_REQ = 5;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_TIMER_AB = 8'h0c;
    localparam logic [7:0] REG_TIMER_CD = 8'h10;
    localparam logic [7:0] REG_RELOAD_AB = 8'h14;
    localparam logic [7:0] REG_RELOAD_CD = 8'h18;
    localparam logic [7:0] REG_SKIP_CNT = 8'h1c;
    // Reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef struct packed {
        logic [9:0] word;
        logic valid;
    } sktl_instr_t;

    typedef struct packed {
        logic [3:0] irq_ctrl_b;
        logic [3:0] irq_en_a;
        logic [3:0] irq_en_b;
        logic [3:0] acc;
        logic [3:0] reg_b;
        logic [3:0] mem_nibble;
        logic carry;
        logic powerdown_flag;
        logic [NUM_TIMER_REQ-1:0] timer_req;
        logic vdet_armed;
        logic skip_pend;
        logic [7:0] timer_a;
        logic [7:0] timer_b;
        logic [7:0] timer_c;
        logic [7:0] timer_d;
        logic [7:0] timer_a_reload;
        logic [7:0] timer_b_reload;
        logic [7:0] timer_c_reload;
        logic [7:0] timer_d_first_reload;
        logic [15:0] skip_cnt;
        logic [31:0] prdata;
    } sktl_state_t;
endpackage
`default_nettype wire

// ==== design/sktl_core.sv ====
// Execution of the skip-test and timer-load instruction group
// Function
// RULE_01: Pin-B skip compares pin to polarity bit 2 of pin-B control register.
// RULE_02: Powerdown skip skips when flag is 1; flag stays unchanged.
// RULE_03: Timer A test gated by enable bit 2 of register A.
// RULE_04: Timer B test gated by enable bit 3 of register A.
// RULE_05: Timer C test gated by enable bit 0 of register B.
// RULE_06: Timer D test gated by enable bit 3 of register B.
// RULE_07: Timer E test gated by enable bit 1 of register B.
// RULE_08: Enable bit set makes the timer test a no-operation.
// RULE_09: Skipping timer test clears its request flag.
// RULE_10: Arm instruction keeps drop detector alive in power down while pin high.
// RULE_11: Bit test skips when selected bit j of pointed nibble is 0.
// RULE_12: Carry test skips when carry is 0, carry unchanged.
// RULE_13: Timer A-C loads write same byte to count and reload.
// RULE_14: Register B goes to high nibble of timer and reload.
// RULE_15: Accumulator goes to low nibble of timer and reload.
// RULE_16: Timer D load writes count and first reload only.
// RULE_17: Each instruction is one word and one cycle.
// RULE_18: Skip suppresses next word's effects but the counter advances.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module sktl_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire sktl_pkg::sktl_instr_t instr,
    output logic pc_advance,
    output logic instr_skipped,
    input wire logic ext_pin_b_async,
    input wire logic detector_control_pin_async,
    input wire logic [sktl_pkg::NUM_TIMER_REQ-1:0] timer_req_set,
    input wire logic powerdown_set,
    input wire logic powerdown_clr,
    output logic vdet_active,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sktl_pkg::*;

    sktl_state_t s_q;
    sktl_state_t s_d;
    logic [1:0] pin_sync_q;
    logic [1:0] detector_control_pin_sync_q;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic executes;
    logic skip_now;
    logic arm_now;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_q <= 2'b00;
            detector_control_pin_sync_q <= 2'b00;
        end else begin
            pin_sync_q <= {pin_sync_q[0], ext_pin_b_async};
            detector_control_pin_sync_q <= {detector_control_pin_sync_q[0], detector_control_pin_async};
        end
    end

    function automatic logic [7:0] join_ab(input logic [3:0] b, input logic [3:0] a);
        join_ab = {b, a}; // RULE_14 RULE_15
    endfunction

    function automatic logic valid_addr(input logic [7:0] a);
        valid_addr = (a == REG_CTRL) || (a == REG_FLAGS) || (a == REG_ACC)
            || (a == REG_TIMER_AB) || (a == REG_TIMER_CD) || (a == REG_RELOAD_AB)
            || (a == REG_RELOAD_CD) || (a == REG_SKIP_CNT);
    endfunction

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign addr_ok = valid_addr(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = s_q.prdata;
    // Skip-pending word is fetched but has no effect
    assign executes = instr.valid && !s_q.skip_pend; // RULE_18
    assign pc_advance = instr.valid; // RULE_17 RULE_18
    assign instr_skipped = instr.valid && s_q.skip_pend;
    assign vdet_active = s_q.vdet_armed && detector_control_pin_sync_q[1]; // RULE_10

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_d = s_q;
        skip_now = 1'b0;
        arm_now = 1'b0;
        // Hardware set beats any clear in the same cycle, so sets go last
        if (instr.valid) begin
            s_d.skip_pend = 1'b0;
            if (s_q.skip_pend) begin
                s_d.skip_cnt = s_q.skip_cnt + 16'h0001;
            end
        end
        if (executes) begin
            case (instr.word)
                OP_SKIP_EXT_PIN_B: begin
                    skip_now = (pin_sync_q[1] == s_q.irq_ctrl_b[EXT_PIN_B_POL_BIT]); // RULE_01
                end
                OP_SKIP_POWERDOWN: begin
                    skip_now = s_q.powerdown_flag; // RULE_02
                end
                OP_SKIP_TIMER_A: begin
                    if (!s_q.irq_en_a[TIMER_A_IE_BIT] && s_q.timer_req[0]) begin // RULE_03 RULE_08
                        skip_now = 1'b1;
                        s_d.timer_req[0] = 1'b0; // RULE_09
                    end
                end
                OP_SKIP_TIMER_B: begin
                    if (!s_q.irq_en_a[TIMER_B_IE_BIT] && s_q.timer_req[1]) begin // RULE_04 RULE_08
                        skip_now = 1'b1;
                        s_d.timer_req[1] = 1'b0; // RULE_09
                    end
                end
                OP_SKIP_TIMER_C: begin
                    if (!s_q.irq_en_b[TIMER_C_IE_BIT] && s_q.timer_req[2]) begin // RULE_05 RULE_08
                        skip_now = 1'b1;
                        s_d.timer_req[2] = 1'b0; // RULE_09
                    end
                end
                OP_SKIP_TIMER_D: begin
                    if (!s_q.irq_en_b[TIMER_D_IE_BIT] && s_q.timer_req[3]) begin // RULE_06 RULE_08
                        skip_now = 1'b1;
                        s_d.timer_req[3] = 1'b0; // RULE_09
                    end
                end
                OP_SKIP_TIMER_E: begin
                    if (!s_q.irq_en_b[TIMER_E_IE_BIT] && s_q.timer_req[4]) begin // RULE_07 RULE_08
                        skip_now = 1'b1;
                        s_d.timer_req[4] = 1'b0; // RULE_09
                    end
                end
                OP_ARM_VDET: begin
                    arm_now = 1'b1; // RULE_10
                end
                OP_SKIP_CARRY: begin
                    skip_now = !s_q.carry; // RULE_12
                end
                OP_LOAD_TIMER_A: begin
                    s_d.timer_a = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                    s_d.timer_a_reload = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                end
                OP_LOAD_TIMER_B: begin
                    s_d.timer_b = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                    s_d.timer_b_reload = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                end
                OP_LOAD_TIMER_C: begin
                    s_d.timer_c = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                    s_d.timer_c_reload = join_ab(s_q.reg_b, s_q.acc); // RULE_13
                end
                OP_LOAD_TIMER_D: begin
                    s_d.timer_d = join_ab(s_q.reg_b, s_q.acc); // RULE_16
                    s_d.timer_d_first_reload = join_ab(s_q.reg_b, s_q.acc); // RULE_16
                end
                default: begin
                    if (instr.word[9:2] == OP_SKIP_BIT_BASE[9:2]) begin
                        skip_now = !s_q.mem_nibble[instr.word[1:0]]; // RULE_11
                    end
                end
            endcase
            s_d.skip_pend = skip_now;
        end
        // Software writes, lowest priority for hardware-set bits
        if (apb_wr && addr_ok) begin
            case (paddr)
                REG_CTRL: begin
                    s_d.irq_ctrl_b = pwdata[3:0];
                    s_d.irq_en_a = pwdata[7:4];
                    s_d.irq_en_b = pwdata[11:8];
                    s_d.vdet_armed = pwdata[12];
                end
                REG_FLAGS: begin
                    // Write one to clear the request flags
                    s_d.timer_req = s_d.timer_req & ~pwdata[4:0];
                    s_d.carry = pwdata[8];
                end
                REG_ACC: begin
                    s_d.acc = pwdata[3:0];
                    s_d.reg_b = pwdata[7:4];
                    s_d.mem_nibble = pwdata[11:8];
                end
                default: begin
                end
            endcase
        end
        // Arming beats a software clear in the same cycle
        if (arm_now) begin
            s_d.vdet_armed = 1'b1; // RULE_10
        end
        s_d.timer_req = s_d.timer_req | timer_req_set;
        if (powerdown_clr) begin
            s_d.powerdown_flag = 1'b0;
        end
        if (powerdown_set) begin
            s_d.powerdown_flag = 1'b1;
        end
        if (apb_rd) begin
            case (paddr)
                REG_CTRL: s_d.prdata = {19'h0, s_q.vdet_armed, s_q.irq_en_b,
                    s_q.irq_en_a, s_q.irq_ctrl_b};
                REG_FLAGS: s_d.prdata = {22'h0, s_q.powerdown_flag, s_q.carry,
                    3'h0, s_q.timer_req};
                REG_ACC: s_d.prdata = {20'h0, s_q.mem_nibble, s_q.reg_b, s_q.acc};
                REG_TIMER_AB: s_d.prdata = {16'h0, s_q.timer_b, s_q.timer_a};
                REG_TIMER_CD: s_d.prdata = {16'h0, s_q.timer_d, s_q.timer_c};
                REG_RELOAD_AB: s_d.prdata = {16'h0, s_q.timer_b_reload, s_q.timer_a_reload};
                REG_RELOAD_CD: s_d.prdata = {16'h0, s_q.timer_d_first_reload,
                    s_q.timer_c_reload};
                REG_SKIP_CNT: s_d.prdata = {16'h0, s_q.skip_cnt};
                default: s_d.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence carry_test_clear;
        executes && instr.word == OP_SKIP_CARRY && !s_q.carry;
    endsequence

    sequence skipped_word;
        instr.valid && s_q.skip_pend;
    endsequence

    sequence load_a_now;
        executes && instr.word == OP_LOAD_TIMER_A;
    endsequence

    pin_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        executes && instr.word == OP_SKIP_EXT_PIN_B
        |=> s_q.skip_pend == ($past(pin_sync_q[1]) == $past(s_q.irq_ctrl_b[2])))
        else $error("pin skip mismatch");
    pd_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        executes && instr.word == OP_SKIP_POWERDOWN && !powerdown_clr && !powerdown_set
        |=> s_q.skip_pend == $past(s_q.powerdown_flag) && $stable(s_q.powerdown_flag))
        else $error("powerdown skip wrong");
    timer_a_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        executes && instr.word == OP_SKIP_TIMER_A && !s_q.irq_en_a[2] && s_q.timer_req[0]
        && !timer_req_set[0] |=> s_q.skip_pend && !s_q.timer_req[0])
        else $error("timer a test failed");
    timer_nop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        executes && instr.word == OP_SKIP_TIMER_C && s_q.irq_en_b[0]
        && !(apb_wr && paddr == REG_FLAGS)
        |=> !s_q.skip_pend && s_q.timer_req[2] == $past(s_q.timer_req[2] | timer_req_set[2]))
        else $error("timer test not a no-op");
    timer_d_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        executes && instr.word == OP_SKIP_TIMER_D && !s_q.timer_req[3] |=> !s_q.skip_pend)
        else $error("timer d skipped without flag");
    carry_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        carry_test_clear |=> s_q.skip_pend ##0 (instr.valid ? !executes : 1'b1))
        else $error("carry skip missing");
    bit_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        executes && instr.word[9:2] == 8'h08
        |=> s_q.skip_pend == !$past(s_q.mem_nibble[instr.word[1:0]]))
        else $error("bit skip wrong");
    load_pair_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        executes && instr.word == OP_LOAD_TIMER_B
        |=> s_q.timer_b == s_q.timer_b_reload && s_q.timer_b == {$past(s_q.reg_b), $past(s_q.acc)})
        else $error("timer b load mismatch");
    first_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
        executes && instr.word == OP_LOAD_TIMER_D
        |=> s_q.timer_d_first_reload == {$past(s_q.reg_b), $past(s_q.acc)})
        else $error("timer d load mismatch");
    skip_suppress_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        s_q.skip_pend && instr.valid && instr.word == OP_LOAD_TIMER_A && !(apb_wr)
        |=> s_q.timer_a == $past(s_q.timer_a))
        else $error("skipped word took effect");
    timer_b_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        executes && instr.word == OP_SKIP_TIMER_B && !s_q.irq_en_a[TIMER_B_IE_BIT]
        && s_q.timer_req[1] && !timer_req_set[1] |=> s_q.skip_pend && !s_q.timer_req[1])
        else $error("timer b test failed");
    timer_c_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        executes && instr.word == OP_SKIP_TIMER_C && !s_q.irq_en_b[TIMER_C_IE_BIT]
        && s_q.timer_req[2] && !timer_req_set[2] |=> s_q.skip_pend && !s_q.timer_req[2])
        else $error("timer c test failed");
    timer_d_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        executes && instr.word == OP_SKIP_TIMER_D && !s_q.irq_en_b[TIMER_D_IE_BIT]
        && s_q.timer_req[3] && !timer_req_set[3] |=> s_q.skip_pend && !s_q.timer_req[3])
        else $error("timer d test failed");
    timer_e_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        executes && instr.word == OP_SKIP_TIMER_E && !s_q.irq_en_b[TIMER_E_IE_BIT]
        && s_q.timer_req[4] && !timer_req_set[4] |=> s_q.skip_pend && !s_q.timer_req[4])
        else $error("timer e test failed");
    timer_a_nop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        executes && instr.word == OP_SKIP_TIMER_A && s_q.irq_en_a[TIMER_A_IE_BIT]
        && !(apb_wr && paddr == REG_FLAGS)
        |=> !s_q.skip_pend && s_q.timer_req[0] == $past(s_q.timer_req[0] | timer_req_set[0]))
        else $error("timer a test not a no-op");
    timer_e_nop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        executes && instr.word == OP_SKIP_TIMER_E && s_q.irq_en_b[TIMER_E_IE_BIT]
        && !(apb_wr && paddr == REG_FLAGS)
        |=> !s_q.skip_pend && s_q.timer_req[4] == $past(s_q.timer_req[4] | timer_req_set[4]))
        else $error("timer e test not a no-op");
    timer_b_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        executes && instr.word == OP_SKIP_TIMER_B && !s_q.timer_req[1] |=> !s_q.skip_pend)
        else $error("timer b skipped without flag");
    vdet_arm_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        executes && instr.word == OP_ARM_VDET |=> s_q.vdet_armed)
        else $error("detector not armed");
    carry_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        executes && instr.word == OP_SKIP_CARRY && !(apb_wr && paddr == REG_FLAGS)
        |=> $stable(s_q.carry))
        else $error("carry test changed carry");
    carry_run_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        executes && instr.word == OP_SKIP_CARRY && s_q.carry |=> !s_q.skip_pend)
        else $error("carry set but skipped");
    load_nibbles_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14 RULE_15
        load_a_now |=> s_q.timer_a_reload[7:4] == $past(s_q.reg_b)
        && s_q.timer_a_reload[3:0] == $past(s_q.acc) && s_q.timer_a == s_q.timer_a_reload)
        else $error("timer a nibbles misplaced");
    load_c_pair_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        executes && instr.word == OP_LOAD_TIMER_C
        |=> s_q.timer_c == s_q.timer_c_reload && s_q.timer_c == {$past(s_q.reg_b), $past(s_q.acc)})
        else $error("timer c load mismatch");
    timer_d_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
        executes && instr.word == OP_LOAD_TIMER_D
        |=> s_q.timer_d == {$past(s_q.reg_b), $past(s_q.acc)})
        else $error("timer d count mismatch");
    skip_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        skipped_word |=> !s_q.skip_pend && s_q.skip_cnt == $past(s_q.skip_cnt) + 16'h0001)
        else $error("skipped word not counted");
    skip_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        !instr.valid |=> $stable(s_q.skip_pend))
        else $error("pending skip lost between words");
    skip_arm_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        skipped_word ##0 (instr.word == OP_ARM_VDET && !s_q.vdet_armed && !apb_wr)
        |=> !s_q.vdet_armed)
        else $error("skipped arm took effect");
endmodule
`default_nettype wire

// ==== dv/sktl_prog_mem.sv ====
// Program memory model that feeds instruction words to the core
`default_nettype none
module sktl_prog_mem (
    input wire logic pclk,
    input wire logic presetn,
    output var sktl_pkg::sktl_instr_t instr
);
    timeunit 1ns;
    timeprecision 1ps;
    import sktl_pkg::*;
    logic [9:0] q[$];

    // ****************************************
    // Word delivery
    // ****************************************
    // Idle word keeps toggling so a stale opcode never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= '0;
        end else if (q.size() > 0) begin
            instr <= {q.pop_front(), 1'b1};
        end else begin
            instr <= {~instr.word, 1'b0};
        end
    end
endmodule
`default_nettype wire

// ==== dv/test_skip_test_and_timer_load_ops.sv ====
// Self-checking bench for the skip-test and timer-load block
`default_nettype none
module test_skip_test_and_timer_load_ops;
    timeunit 1ns;
    timeprecision 1ps;
    import sktl_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pc_advance, instr_skipped, vdet_active;
    logic ext_pin = 0;
    logic det_pin = 0;
    logic pd_set = 0;
    logic pd_clr = 0;
    logic [NUM_TIMER_REQ-1:0] req_set = '0;
    sktl_instr_t instr;
    logic [32:0] exp_q[$];
    logic skip_q[$];
    logic [15:0] exp_skip = 16'h0;
    logic [7:0] t[4];
    logic [3:0] a, b, nib;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 11;
    int ie_bit[5] = '{4 + TIMER_A_IE_BIT, 4 + TIMER_B_IE_BIT, 8 + TIMER_C_IE_BIT,
                      8 + TIMER_D_IE_BIT, 8 + TIMER_E_IE_BIT};

    always #4 pclk = ~pclk;

    sktl_core DUT (.pclk(pclk), .presetn(presetn), .instr(instr), .pc_advance(pc_advance),
        .instr_skipped(instr_skipped), .ext_pin_b_async(ext_pin),
        .detector_control_pin_async(det_pin), .timer_req_set(req_set),
        .powerdown_set(pd_set), .powerdown_clr(pd_clr), .vdet_active(vdet_active),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sktl_prog_mem mem (.pclk(pclk), .presetn(presetn), .instr(instr));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask

    // Victim word follows every tested word; a skip must swallow it
    task automatic exec(input logic [9:0] op, input logic [9:0] vic, input logic sk);
        @(negedge pclk);
        mem.q.push_back(op);
        mem.q.push_back(vic);
        skip_q.push_back(1'b0);
        skip_q.push_back(sk);
        exp_skip = exp_skip + {15'h0, sk};
        repeat (4) @(posedge pclk);
        rd(REG_SKIP_CNT, {17'h0, exp_skip});
    endtask

    // Read results are judged where they appear, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() > 0) begin
                check({pslverr, prdata}, exp_q.pop_front());
            end else begin
                check({pslverr, prdata}, 33'h1ffffffff);
            end
        end
        if (presetn) begin
            if (instr.valid === 1'b1 && skip_q.size() > 0) begin
                check({instr_skipped, pc_advance}, {skip_q.pop_front(), 1'b1});
            end else begin
                check({instr_skipped, pc_advance}, 33'h0);
            end
        end
    end

    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_FLAGS, 33'h0);
        rd(8'h20, {1'b1, 32'h0});
        wr(8'h24, 32'hffffffff);
        rd(REG_CTRL, 33'h0);
        for (int i = 0; i < 4; i++) begin
            a = 4'($random(seed));
            b = 4'($random(seed));
            t[i] = {b, a};
            wr(REG_ACC, {24'h0, b, a});
            exec(OP_LOAD_TIMER_A + 10'(i), 10'h000, 1'b0);
        end
        rd(REG_TIMER_AB, {17'h0, t[1], t[0]});
        rd(REG_TIMER_CD, {17'h0, t[3], t[2]});
        rd(REG_RELOAD_AB, {17'h0, t[1], t[0]});
        rd(REG_RELOAD_CD, {17'h0, t[3], t[2]});
        wr(REG_ACC, {24'h0, ~t[0]});
        wr(REG_FLAGS, 32'h0);
        exec(OP_SKIP_CARRY, OP_LOAD_TIMER_A, 1'b1);
        rd(REG_TIMER_AB, {17'h0, t[1], t[0]});
        wr(REG_FLAGS, 32'h100);
        exec(OP_SKIP_CARRY, OP_LOAD_TIMER_A, 1'b0);
        rd(REG_FLAGS, 33'h100);
        rd(REG_TIMER_AB, {17'h0, t[1], ~t[0]});
        wr(REG_FLAGS, 32'h1f);
        for (int i = 0; i < NUM_TIMER_REQ; i++) begin
            for (int en = 0; en < 2; en++) begin
                wr(REG_CTRL, (en != 0) ? 32'h1 << ie_bit[i] : 32'h0);
                exec(OP_SKIP_TIMER_A + 10'(i), 10'h000, 1'b0);
                req_set <= 5'h1 << i;
                @(posedge pclk);
                req_set <= '0;
                exec(OP_SKIP_TIMER_A + 10'(i), 10'h000, en == 0);
                rd(REG_FLAGS, (en != 0) ? 33'h1 << i : 33'h0);
                wr(REG_FLAGS, 32'h1f);
            end
        end
        for (int k = 0; k < 2; k++) begin
            nib = (k == 0) ? 4'($random(seed)) : ~nib;
            wr(REG_ACC, {20'h0, nib, 8'h00});
            for (int j = 0; j < 4; j++) exec(OP_SKIP_BIT_BASE + 10'(j), 10'h000, !nib[j]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL, 32'(k / 2) << EXT_PIN_B_POL_BIT);
            ext_pin <= k[0];
            repeat (3) @(posedge pclk);
            exec(OP_SKIP_EXT_PIN_B, 10'h000, k[0] == k[1]);
        end
        pd_set <= 1'b1;
        @(posedge pclk);
        pd_set <= 1'b0;
        exec(OP_SKIP_POWERDOWN, OP_ARM_VDET, 1'b1);
        rd(REG_FLAGS, 33'h200);
        pd_clr <= 1'b1;
        @(posedge pclk);
        pd_clr <= 1'b0;
        exec(OP_SKIP_POWERDOWN, 10'h000, 1'b0);
        det_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        check({32'h0, vdet_active}, 33'h0);
        exec(OP_ARM_VDET, 10'h000, 1'b0);
        check({32'h0, vdet_active}, 33'h1);
        det_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        check({32'h0, vdet_active}, 33'h0);
        rd(REG_CTRL, 33'h1004);
        repeat (2) @(posedge pclk);
        print_verdict();
    end
endmodule
`default_nettype wire
